// [ectp_top.v]
// Two 8-bit compare timers with a register port and a divided count clock.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ectp_map.vh"
module ectp_top (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire osc_sel,
  output reg [7:0] rdata_reg,
  output reg unit0_out_reg,
  output reg unit1_out_reg
);
  // Software-visible registers of both units.
  reg [7:0] unit0_mode_register;
  reg [7:0] unit1_mode_register;
  reg [7:0] per0_reg;
  reg [7:0] per1_reg;
  reg [7:0] unit0_duty_compare;
  reg [7:0] unit1_duty_compare;
  // Shared prescaler and the oscillator-select synchroniser.
  reg [7:0] prescale_reg;
  reg osc_s1_reg;
  reg osc_s2_reg;
  reg [7:0] rdata_next;
  // Per-unit buses, unit 1 in the upper byte.
  wire [15:0] mode_bus;
  wire [15:0] period_bus;
  wire [15:0] duty_bus;
  wire [15:0] count_bus;
  wire [15:0] active_bus;
  wire [1:0] pwm_raw;
  wire [1:0] armed;
  wire [1:0] tick;
  wire [1:0] duty_wr;
  wire [1:0] count_en;
  wire unit0_count_enable;
  wire unit1_count_enable;

  assign unit0_count_enable = unit0_mode_register[`ECTP_MODE_EN];
  assign unit1_count_enable = unit1_mode_register[`ECTP_MODE_EN];
  assign count_en = {unit1_count_enable, unit0_count_enable};
  assign mode_bus = {unit1_mode_register, unit0_mode_register};
  assign period_bus = {per1_reg, per0_reg};
  assign duty_bus = {unit1_duty_compare, unit0_duty_compare};

  // Selects a tick from the prescaler; an oscillator-run processor forces the /128 tap.
  function tick_of;
    input [2:0] cks;
    input [7:0] pre;
    input osc;
    reg [2:0] sel;
    begin
      sel = osc ? `ECTP_CKS_OSC128 : cks;
      case (sel)
        3'h0: tick_of = 1'b1;
        3'h1: tick_of = (pre[0] == 1'b1);
        3'h2: tick_of = (pre[1:0] == 2'h3);
        3'h3: tick_of = (pre[3:0] == 4'hf);
        3'h4: tick_of = (pre[5:0] == 6'h3f);
        3'h5: tick_of = (pre[6:0] == 7'h7f);
        default: tick_of = (pre == 8'hff);
      endcase
    end
  endfunction

  // Writes the mode byte; only the enable bit may change while counting.
  function [7:0] mode_wr;
    input [7:0] old;
    input [7:0] nv;
    begin
      if (old[`ECTP_MODE_EN]) begin
        mode_wr = old;
        mode_wr[`ECTP_MODE_EN] = nv[`ECTP_MODE_EN];
      end else begin
        mode_wr = nv;
      end
    end
  endfunction

  // Matches the register index against one map entry; used by the write decode only, the read decode has its own case.
  function reg_hit;
    input [3:0] a;
    input [3:0] idx;
    begin
      reg_hit = (a == idx);
    end
  endfunction

  // Two-flop synchroniser for the asynchronous oscillator-select level.
  always @(posedge clk) begin
    if (rst) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= osc_sel;
      osc_s2_reg <= osc_s1_reg;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      prescale_reg <= 8'h00;
    end else begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      unit0_mode_register <= `ECTP_MODE_RST;
      unit1_mode_register <= `ECTP_MODE_RST;
    end else if (wr) begin
      if (reg_hit(addr, `ECTP_U0_MODE)) begin
        unit0_mode_register <= mode_wr(unit0_mode_register, wdata);
      end
      if (reg_hit(addr, `ECTP_U1_MODE)) begin
        unit1_mode_register <= mode_wr(unit1_mode_register, wdata);
      end
    end
  end

  // A running unit keeps its period; writes while counting are dropped.
  always @(posedge clk) begin
    if (rst) begin
      per0_reg <= `ECTP_PERIOD_RST;
      per1_reg <= `ECTP_PERIOD_RST;
    end else if (wr) begin
      if (reg_hit(addr, `ECTP_U0_PERIOD) && !unit0_count_enable) begin
        per0_reg <= wdata;
      end
      if (reg_hit(addr, `ECTP_U1_PERIOD) && !unit1_count_enable) begin
        per1_reg <= wdata;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      unit0_duty_compare <= `ECTP_DUTY_RST;
      unit1_duty_compare <= `ECTP_DUTY_RST;
    end else if (wr) begin
      if (reg_hit(addr, `ECTP_U0_DUTY)) begin
        unit0_duty_compare <= wdata;
      end
      if (reg_hit(addr, `ECTP_U1_DUTY)) begin
        unit1_duty_compare <= wdata;
      end
    end
  end

  always @* begin
    rdata_next = 8'h00;
    if (rd) begin
      case (addr)
        `ECTP_U0_MODE: rdata_next = unit0_mode_register;
        `ECTP_U1_MODE: rdata_next = unit1_mode_register;
        `ECTP_U0_PERIOD: rdata_next = per0_reg;
        `ECTP_U1_PERIOD: rdata_next = per1_reg;
        `ECTP_U0_DUTY: rdata_next = unit0_duty_compare;
        `ECTP_U1_DUTY: rdata_next = unit1_duty_compare;
        `ECTP_U0_STAT: rdata_next = count_bus[7:0];
        `ECTP_U1_STAT: rdata_next = count_bus[15:8];
        `ECTP_ARMED: rdata_next = {6'h00, armed};
        `ECTP_U0_ACTIVE: rdata_next = active_bus[7:0];
        `ECTP_U1_ACTIVE: rdata_next = active_bus[15:8];
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Every top output leaves through a flop of its own.
  always @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
      unit0_out_reg <= 1'b0;
      unit1_out_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      unit0_out_reg <= pwm_raw[0];
      unit1_out_reg <= pwm_raw[1];
    end
  end

  // Unit 1 carrier mode relies on software keeping its clock fast enough.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_unit
      assign tick[gi] = tick_of(mode_bus[8 * gi + `ECTP_MODE_CKS_HI -: 3], prescale_reg, osc_s2_reg);
      assign duty_wr[gi] = wr & reg_hit(addr, (gi == 0) ? `ECTP_U0_DUTY : `ECTP_U1_DUTY);
      ectp_unit u_unit (
        .clk(clk),
        .rst(rst),
        .tick(tick[gi]),
        .en(count_en[gi]),
        .op(mode_bus[8 * gi + `ECTP_MODE_OP_HI -: 2]),
        .period(period_bus[8 * gi + 7 -: 8]),
        .duty(duty_bus[8 * gi + 7 -: 8]),
        .duty_wr(duty_wr[gi]),
        .pwm_out_reg(pwm_raw[gi]),
        .count_reg(count_bus[8 * gi + 7 -: 8]),
        .duty_armed_reg(armed[gi]),
        .active_duty_reg(active_bus[8 * gi + 7 -: 8])
      );
    end
  endgenerate
endmodule // ectp_top
`default_nettype wire

// [ectp_map.vh]
// Register offsets, field positions, reset values and timing counts of the compare timer pair.
// Operation
// - Unit 0 PWM duty needs rewrite after restart.
// - Unit 1 duty needs rewrite after every restart.
// - New duty applied after three count clocks.
// - Oscillator source is divided before counting.
`ifndef ECTP_MAP_VH
`define ECTP_MAP_VH
`define ECTP_ADDR_W 4
`define ECTP_U0_MODE 4'h0
`define ECTP_U0_PERIOD 4'h1
`define ECTP_U0_DUTY 4'h2
`define ECTP_U0_STAT 4'h3
`define ECTP_U1_MODE 4'h4
`define ECTP_U1_PERIOD 4'h5
`define ECTP_U1_DUTY 4'h6
`define ECTP_U1_STAT 4'h7
`define ECTP_ARMED 4'h8
`define ECTP_U0_ACTIVE 4'h9
`define ECTP_U1_ACTIVE 4'ha
`define ECTP_MODE_EN 7
`define ECTP_MODE_OP_HI 5
`define ECTP_MODE_OP_LO 4
`define ECTP_MODE_CKS_HI 2
`define ECTP_MODE_CKS_LO 0
`define ECTP_OP_INTERVAL 2'h0
`define ECTP_OP_PWM 2'h2
`define ECTP_OP_CARRIER 2'h1
`define ECTP_MODE_RST 8'h00
`define ECTP_PERIOD_RST 8'h00
`define ECTP_DUTY_RST 8'h00
`define ECTP_XFER_CLKS 2'h3
`define ECTP_CKS_OSC128 3'h5
`endif

// [ectp_unit.v]
// One 8-bit compare timer unit with period, duty and PWM output.
`timescale 1ns/1ps
`default_nettype none
`include "ectp_map.vh"
module ectp_unit (
  input wire clk,
  input wire rst,
  input wire tick,
  input wire en,
  input wire [1:0] op,
  input wire [7:0] period,
  input wire [7:0] duty,
  input wire duty_wr,
  output reg pwm_out_reg,
  output reg [7:0] count_reg,
  output reg duty_armed_reg,
  output reg [7:0] active_duty_reg
);
  reg en_d_reg;
  reg pend_reg;
  reg [1:0] wait_reg;
  wire start;
  assign start = en & ~en_d_reg;

  always @(posedge clk) begin
    if (rst) begin
      en_d_reg <= 1'b0;
      pend_reg <= 1'b0;
      wait_reg <= 2'h0;
      duty_armed_reg <= 1'b0;
      active_duty_reg <= `ECTP_DUTY_RST;
      count_reg <= 8'h00;
      pwm_out_reg <= 1'b0;
    end else begin
      en_d_reg <= en;
      // A restart drops the loaded duty until software writes it again.
      if (start) begin
        duty_armed_reg <= 1'b0;
      end
      if (duty_wr) begin
        pend_reg <= 1'b1;
        wait_reg <= 2'h0;
      end else if (start) begin
        // A value written before the restart must not load after it.
        pend_reg <= 1'b0;
      end else if (pend_reg && tick) begin
        if (wait_reg == `ECTP_XFER_CLKS - 2'h1) begin
          pend_reg <= 1'b0;
          active_duty_reg <= duty;
          duty_armed_reg <= 1'b1;
        end else begin
          wait_reg <= wait_reg + 2'h1;
        end
      end
      if (!en) begin
        count_reg <= 8'h00;
        pwm_out_reg <= 1'b0;
      end else if (start) begin
        count_reg <= 8'h00;
        pwm_out_reg <= (op != `ECTP_OP_INTERVAL);
      end else if (tick) begin
        if (count_reg == period) begin
          count_reg <= 8'h00;
          pwm_out_reg <= (op != `ECTP_OP_INTERVAL);
        end else begin
          count_reg <= count_reg + 8'h01;
          if (op != `ECTP_OP_INTERVAL && duty_armed_reg && count_reg == active_duty_reg) begin
            pwm_out_reg <= 1'b0;
          end
        end
      end
    end
  end
endmodule // ectp_unit
`default_nettype wire

// [ectp_assertions.sv]
// Port checker for the compare timer pair.
`timescale 1ns/1ps
`default_nettype none
module ectp_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic osc_sel,
  input wire logic [7:0] rdata_reg,
  input wire logic unit0_out_reg,
  input wire logic unit1_out_reg
);
  logic [1:0] en_reg;
  logic [1:0] dw_reg;
  logic [2:0] age0_reg;
  logic [2:0] age1_reg;
  wire logic mode_wr = wr && addr[3] == 1'b0 && addr[1:0] == 2'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadows of each unit's enable and of a duty write since the last start.
  always_ff @(posedge clk) begin
    if (rst) begin
      en_reg <= 2'h0;
      dw_reg <= 2'h0;
    end else if (mode_wr) begin
      en_reg[addr[2]] <= wdata[7];
      if (wdata[7] && !en_reg[addr[2]]) dw_reg[addr[2]] <= 1'b0;
    end else if (wr && addr[3] == 1'b0 && addr[1:0] == 2'h2) begin
      dw_reg[addr[2]] <= 1'b1;
    end
  end
  // Saturating count of cycles each unit has run, so a stop-start blip is not taken for a running unit.
  always_ff @(posedge clk) begin
    if (rst || !en_reg[0]) age0_reg <= 3'h0;
    else if (age0_reg != 3'h7) age0_reg <= age0_reg + 3'h1;
    if (rst || !en_reg[1]) age1_reg <= 3'h0;
    else if (age1_reg != 3'h7) age1_reg <= age1_reg + 3'h1;
  end
  sequence s_start0;
    mode_wr && addr[2] == 1'b0 && wdata[7] && !en_reg[0] && wdata[5:4] == 2'h2 && !osc_sel;
  endsequence
  chk_rdata_idle: assert property (!rd |=> rdata_reg == 8'h00) else $error("read data without read");
  chk_reset_quiet: assert property ($fell(rst) |-> !unit0_out_reg && !unit1_out_reg) else $error("output after reset");
  chk_start_high: assert property (s_start0 |-> ##[1:300] unit0_out_reg) else $error("no output at start");
  chk_unit0_hold: assert property (en_reg[0] && age0_reg == 3'h7 && !dw_reg[0] |-> !$fell(unit0_out_reg))
    else $error("unit0 duty used without rewrite");
  chk_unit1_hold: assert property (en_reg[1] && age1_reg == 3'h7 && !dw_reg[1] |-> !$fell(unit1_out_reg))
    else $error("unit1 duty used without rewrite");
endmodule // ectp_checker
bind ectp_top ectp_checker u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .osc_sel(osc_sel), .rdata_reg(rdata_reg), .unit0_out_reg(unit0_out_reg), .unit1_out_reg(unit1_out_reg));
`default_nettype wire

// [eight_bit_compare_timer_pair_bench.sv]
// Self-checking bench for the compare timer pair.
`timescale 1ns/1ps
`default_nettype none
`include "ectp_map.vh"
module eight_bit_compare_timer_pair_bench;
  logic clk, rst, wr, rd, osc_sel;
  logic [3:0] addr;
  logic [7:0] wdata;
  wire logic [7:0] rdata_reg;
  wire logic unit0_out_reg, unit1_out_reg;
  int failures, cmp_count;
  ectp_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .osc_sel(osc_sel),
    .rdata_reg(rdata_reg), .unit0_out_reg(unit0_out_reg), .unit1_out_reg(unit1_out_reg));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(name, {8'h00, rdata_reg & m}, {8'h00, exp});
  endtask
  // Counts clocks between two rising edges of a unit output.
  task automatic period_chk(input logic u, input int exp);
    int k, n, len;
    logic p, c;
    n = 0;
    len = 0;
    p = 1'b1;
    for (k = 0; k < 3000 && n < 2; k++) begin
      @(posedge clk);
      #1;
      c = u ? unit1_out_reg : unit0_out_reg;
      if (n == 1) len++;
      if (c === 1'b1 && p === 1'b0) n++;
      p = c;
    end
    if (n < 2) begin
      failures++;
      conclude();
    end
    check("period", len[15:0], exp[15:0]);
  endtask
  task automatic t_lock();
    rd_chk("unmapped", 4'hf, 8'h00, 8'hff);
    wr_reg(4'h4, 8'h23);
    wr_reg(4'h5, 8'h10);
    wr_reg(4'h4, 8'ha3);
    wr_reg(4'h4, 8'h81);
    rd_chk("locked mode", 4'h4, 8'ha3, 8'hff);
    wr_reg(4'h5, 8'h20);
    rd_chk("locked period", 4'h5, 8'h10, 8'hff);
    wr_reg(4'h4, 8'h01);
    rd_chk("stopped mode", 4'h4, 8'h23, 8'hff);
  endtask
  task automatic t_duty(input logic u, input logic [1:0] op);
    logic [3:0] b;
    logic [7:0] m;
    b = {1'b0, u, 2'h0};
    m = {6'h00, u, !u};
    wr_reg(b, {2'h0, op, 4'h3});
    wr_reg(b + 4'h1, 8'h03);
    wr_reg(b, {2'h2, op, 4'h3});
    wr_reg(b + 4'h2, 8'h01);
    rd_chk("armed early", 4'h8, 8'h00, m);
    repeat (60) @(posedge clk);
    rd_chk("armed", 4'h8, m, m);
    rd_chk("active duty", 4'h9 + {3'h0, u}, 8'h01, 8'hff);
    period_chk(u, 64);
    wr_reg(b, {2'h0, op, 4'h3});
    wr_reg(b + 4'h2, 8'h01);
    wr_reg(b, {2'h2, op, 4'h3});
    rd_chk("armed at restart", 4'h8, 8'h00, m);
    repeat (80) @(posedge clk);
    #1;
    check("held high", {15'h0000, (u ? unit1_out_reg : unit0_out_reg)}, 16'h0001);
    wr_reg(b, {2'h0, op, 4'h3});
  endtask
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    osc_sel = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_lock();
    t_duty(1'b1, `ECTP_OP_PWM);
    t_duty(1'b1, `ECTP_OP_CARRIER);
    t_duty(1'b0, `ECTP_OP_PWM);
    osc_sel <= 1'b1;
    wr_reg(4'h4, 8'h25);
    wr_reg(4'h4, 8'ha5);
    wr_reg(4'h6, 8'h01);
    period_chk(1'b1, 512);
    conclude();
  end
endmodule // eight_bit_compare_timer_pair_bench
`default_nettype wire
